// ==== pkg/abtm_pkg.sv ====
// Package of constants and types for the analog block test mux control.
package abtm_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int ADR_W = 12;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int IDX_W = 10;
  localparam int REG_W = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_CONTROL_CH1 = 10'h10C;
  localparam logic [IDX_W-1:0] IDX_CONTROL_CH2 = 10'h10D;

  // ----------------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_CONTROL_CH1 = 8'h00;
  localparam logic [REG_W-1:0] RST_CONTROL_CH2 = 8'h00;
  localparam logic [REG_W-1:0] MASK_CONTROL_CH1 = 8'hFF;
  localparam logic [REG_W-1:0] MASK_CONTROL_CH2 = 8'h76;

  // ----------------------------------------------------------------------
  // Field positions, first control register
  // ----------------------------------------------------------------------
  localparam int CH1_DIG_OE = 7;
  localparam int CH1_GAIN = 6;
  localparam int CH1_DIGITAL_TEST_SELECT_HIGH_LO_HI = 5;
  localparam int CH1_DIGITAL_TEST_SELECT_HIGH_LO_LO = 4;
  localparam int CH1_LOCKOUT = 3;
  localparam int CH1_CUR_OFF = 2;
  localparam int CH1_VOLT_OFF = 1;
  localparam int CH1_ANA_OE = 0;

  // ----------------------------------------------------------------------
  // Field positions, second control register
  // ----------------------------------------------------------------------
  localparam int CH2_DIGITAL_TEST_SELECT_HIGH_HI_HI = 6;
  localparam int CH2_DIGITAL_TEST_SELECT_HIGH_HI_LO = 4;
  localparam int CH2_CUR_OFF = 2;
  localparam int CH2_VOLT_OFF = 1;

  // ----------------------------------------------------------------------
  // Test multiplexers
  // ----------------------------------------------------------------------
  localparam int DIGITAL_TEST_SELECT_HIGH_W = 5;
  localparam int DSRC_N = 32;
  localparam int ASEL_W = 5;

  // Bus slave states, one-hot.
  typedef enum logic [1:0] {
    ABTM_BUS_IDLE = 2'b01,
    ABTM_BUS_ACK = 2'b10
  } abtm_bus_e;

endpackage : abtm_pkg

// ==== logic/abtm_dmux.sv ====
// Registered digital test multiplexer choosing one of the internal sources.
module abtm_dmux
  import abtm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Source selection
  input wire logic [abtm_pkg::DIGITAL_TEST_SELECT_HIGH_W-1:0] sel_i,
  input wire logic [abtm_pkg::DSRC_N-1:0] src_i,
  // Selected source
  output logic out_o
);

  logic out_reg;
  logic out_next;

  // A register here keeps the wide select tree off the pin path.
  assign out_next = src_i[sel_i];
  assign out_o = out_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
    end
  end

endmodule : abtm_dmux

// ==== logic/abtm_top.sv ====
// Control registers for amplifier enables and the bench test multiplexers.
//
// The implementer's own choice: the Wishbone interface to the registers.
module abtm_top
  import abtm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [abtm_pkg::ADR_W-1:0] adr_i,
  input wire logic [abtm_pkg::SEL_W-1:0] sel_i,
  input wire logic [abtm_pkg::DAT_W-1:0] dat_i,
  output logic ack_o,
  output logic [abtm_pkg::DAT_W-1:0] dat_o,
  // Amplifier controls
  output logic current_loop_amp_off_ch1_o,
  output logic voltage_loop_amp_off_ch1_o,
  output logic current_loop_amp_off_ch2_o,
  output logic voltage_loop_amp_off_ch2_o,
  output logic aux_amp_gain_select_o,
  output logic gate_drive_lockout_select_o,
  // Analog test path
  input wire logic [abtm_pkg::ASEL_W-1:0] converter_channel_select_i,
  output logic [abtm_pkg::ASEL_W-1:0] analog_mux_select_o,
  output logic analog_buffer_enable_o,
  output logic analog_test_pin_connect_o,
  output logic analog_test_pin_input_keep_o,
  // Digital test path
  input wire logic [abtm_pkg::DSRC_N-1:0] digital_test_source_i,
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  output logic digital_test_pin_o,
  output logic digital_test_pin_oe_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Write merge: only writable bits of an enabled low lane change.
  function automatic logic [REG_W-1:0] merge_write(
    input logic [REG_W-1:0] old_val,
    input logic [REG_W-1:0] new_val,
    input logic [REG_W-1:0] wmask
  );
    merge_write = (old_val & ~wmask) | (new_val & wmask);
  endfunction : merge_write

  // Read value widened to the bus with the upper lanes at zero.
  function automatic logic [DAT_W-1:0] widen(
    input logic [REG_W-1:0] val
  );
    widen = {{(DAT_W-REG_W){1'b0}}, val};
  endfunction : widen

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  abtm_bus_e state_reg;
  abtm_bus_e state_next;
  logic ack_reg;
  logic ack_next;
  logic [DAT_W-1:0] rdata_reg;
  logic [DAT_W-1:0] rdata_next;
  logic [REG_W-1:0] ctrl1_reg;
  logic [REG_W-1:0] ctrl1_next;
  logic [REG_W-1:0] ctrl2_reg;
  logic [REG_W-1:0] ctrl2_next;
  logic [ASEL_W-1:0] asel_reg;
  logic abuf_reg;
  logic aconn_reg;
  logic akeep_reg;
  logic dpin_reg;
  logic dpin_next;
  logic doe_reg;
  logic doe_next;
  logic dmux_out;

  wire logic [IDX_W-1:0] adr_idx = adr_i[ADR_W-1:2];
  wire logic req = cyc_i & stb_i;
  wire logic take = req & (state_reg == ABTM_BUS_IDLE);
  wire logic hit1 = (adr_idx == IDX_CONTROL_CH1);
  wire logic hit2 = (adr_idx == IDX_CONTROL_CH2);
  wire logic lane0 = sel_i[0];
  wire logic wr1 = take & we_i & hit1 & lane0;
  wire logic wr2 = take & we_i & hit2 & lane0;
  wire logic [REG_W-1:0] wbyte = dat_i[REG_W-1:0];
  wire logic [DIGITAL_TEST_SELECT_HIGH_W-1:0] digital_test_select_high = {ctrl2_reg[CH2_DIGITAL_TEST_SELECT_HIGH_HI_HI:CH2_DIGITAL_TEST_SELECT_HIGH_HI_LO],
                                  ctrl1_reg[CH1_DIGITAL_TEST_SELECT_HIGH_LO_HI:CH1_DIGITAL_TEST_SELECT_HIGH_LO_LO]};
  wire logic dig_oe = ctrl1_reg[CH1_DIG_OE];
  wire logic ana_oe = ctrl1_reg[CH1_ANA_OE];

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------

  // Every access, mapped or not, is acknowledged one cycle after it is
  // seen; unmapped reads return zero and unmapped writes are dropped.
  always_comb begin
    state_next = state_reg;
    ack_next = 1'b0;
    case (state_reg)
      ABTM_BUS_IDLE: begin
        if (req) begin
          state_next = ABTM_BUS_ACK;
          ack_next = 1'b1;
        end
      end
      ABTM_BUS_ACK: begin
        state_next = ABTM_BUS_IDLE;
      end
      default: begin
        state_next = ABTM_BUS_IDLE;
      end
    endcase
  end

  // Unimplemented bits of register 2 read as zero through the mask.
  assign rdata_next = !take ? rdata_reg :
                      hit1 ? widen(ctrl1_reg) :
                      hit2 ? widen(ctrl2_reg & MASK_CONTROL_CH2) :
                      '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ABTM_BUS_IDLE;
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------

  // The write lands on the edge that raises ack, so a read that follows
  // back to back already sees it.
  assign ctrl1_next = wr1 ? merge_write(ctrl1_reg, wbyte, MASK_CONTROL_CH1) :
                      ctrl1_reg;
  assign ctrl2_next = wr2 ? merge_write(ctrl2_reg, wbyte, MASK_CONTROL_CH2) :
                      ctrl2_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1_reg <= RST_CONTROL_CH1;
      ctrl2_reg <= RST_CONTROL_CH2;
    end else begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
    end
  end

  // ----------------------------------------------------------------------
  // Analog test path
  // ----------------------------------------------------------------------

  // The select follows the converter field even while the pin is off, so
  // the converter input keeps tracking it; only the buffer enable, pin switch and input keep are gated.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      asel_reg <= '0;
      abuf_reg <= 1'b0;
      aconn_reg <= 1'b0;
      akeep_reg <= 1'b1;
    end else begin
      asel_reg <= converter_channel_select_i;
      abuf_reg <= ana_oe;
      aconn_reg <= ana_oe;
      akeep_reg <= ~ana_oe;
    end
  end

  // ----------------------------------------------------------------------
  // Digital test path
  // ----------------------------------------------------------------------
  abtm_dmux u_dmux (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(digital_test_select_high),
    .src_i(digital_test_source_i),
    .out_o(dmux_out)
  );

  // With the test output off the ordinary pin drive passes untouched,
  // whatever the select fields hold.
  assign dpin_next = dig_oe ? dmux_out : gpio_out_i;
  assign doe_next = dig_oe | gpio_oe_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dpin_reg <= 1'b0;
      doe_reg <= 1'b0;
    end else begin
      dpin_reg <= dpin_next;
      doe_reg <= doe_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign ack_o = ack_reg;
  assign dat_o = rdata_reg;
  assign current_loop_amp_off_ch1_o = ctrl1_reg[CH1_CUR_OFF];
  assign voltage_loop_amp_off_ch1_o = ctrl1_reg[CH1_VOLT_OFF];
  assign current_loop_amp_off_ch2_o = ctrl2_reg[CH2_CUR_OFF];
  assign voltage_loop_amp_off_ch2_o = ctrl2_reg[CH2_VOLT_OFF];
  assign aux_amp_gain_select_o = ctrl1_reg[CH1_GAIN];
  assign gate_drive_lockout_select_o = ctrl1_reg[CH1_LOCKOUT];
  assign analog_mux_select_o = asel_reg;
  assign analog_buffer_enable_o = abuf_reg;
  assign analog_test_pin_connect_o = aconn_reg;
  assign analog_test_pin_input_keep_o = akeep_reg;
  assign digital_test_pin_o = dpin_reg;
  assign digital_test_pin_oe_o = doe_reg;

endmodule : abtm_top

// ==== tb/abtm_top_sva.sv ====
// Port-level checker for the analog block test mux control registers.
module abtm_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [abtm_pkg::ADR_W-1:0] adr_i,
  input wire logic [abtm_pkg::SEL_W-1:0] sel_i,
  input wire logic [abtm_pkg::DAT_W-1:0] dat_i,
  input wire logic ack_o,
  input wire logic [abtm_pkg::DAT_W-1:0] dat_o,
  // Controls
  input wire logic current_loop_amp_off_ch1_o,
  input wire logic voltage_loop_amp_off_ch1_o,
  input wire logic current_loop_amp_off_ch2_o,
  input wire logic voltage_loop_amp_off_ch2_o,
  input wire logic aux_amp_gain_select_o,
  input wire logic gate_drive_lockout_select_o,
  // Analog path
  input wire logic [abtm_pkg::ASEL_W-1:0] converter_channel_select_i,
  input wire logic [abtm_pkg::ASEL_W-1:0] analog_mux_select_o,
  input wire logic analog_buffer_enable_o,
  input wire logic analog_test_pin_connect_o,
  input wire logic analog_test_pin_input_keep_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import abtm_pkg::*;
  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire take = cyc_i && stb_i && !ack_o;
  wire [5:0] amps = {current_loop_amp_off_ch1_o, voltage_loop_amp_off_ch1_o,
    aux_amp_gain_select_o, gate_drive_lockout_select_o,
    current_loop_amp_off_ch2_o, voltage_loop_amp_off_ch2_o};
  sequence wr(a);
    take && we_i && sel_i[0] && adr_i == a;
  endsequence
  sequence rd(a);
    take && !we_i && adr_i == a;
  endsequence
  ack_answer_a: assert property (take |=> ack_o)
    else $error("access not acknowledged");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  reg1_outs_a: assert property (wr(12'h430) |=>
    amps[5:2] == {$past(dat_i[2]), $past(dat_i[1]), $past(dat_i[6]),
    $past(dat_i[3])}) else $error("first register outputs wrong");
  reg2_outs_a: assert property (wr(12'h434) |=>
    amps[1:0] == {$past(dat_i[2]), $past(dat_i[1])})
    else $error("second register outputs wrong");
  rsvd_read_a: assert property (rd(12'h434) |=>
    (dat_o & 32'hFFFFFF89) == 32'h0) else $error("reserved bits read one");
  rst_clear_a: assert property ($fell(rst_i) |-> amps == 6'h0 &&
    analog_test_pin_input_keep_o) else $error("outputs not reset");
  abuf_tie_a: assert property (
    analog_buffer_enable_o == analog_test_pin_connect_o)
    else $error("buffer not with connect");
  akeep_pin_a: assert property (
    analog_test_pin_input_keep_o != analog_test_pin_connect_o)
    else $error("analog pin role clash");
  amux_follow_a: assert property (!$past(rst_i) |->
    analog_mux_select_o == $past(converter_channel_select_i))
    else $error("analog select not following");
  // The pin switch trails the register by one flop, so it is checked
  // two edges after the write is taken.
  ana_conn_a: assert property (wr(12'h430) |=> ##1
    analog_test_pin_connect_o == $past(dat_i[0], 2))
    else $error("analog connect not following bit");
endmodule : abtm_sva

bind abtm_top abtm_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .ack_o, .dat_o, .current_loop_amp_off_ch1_o,
  .voltage_loop_amp_off_ch1_o, .current_loop_amp_off_ch2_o,
  .voltage_loop_amp_off_ch2_o, .aux_amp_gain_select_o,
  .gate_drive_lockout_select_o, .converter_channel_select_i,
  .analog_mux_select_o, .analog_buffer_enable_o,
  .analog_test_pin_connect_o, .analog_test_pin_input_keep_o);

// ==== tb/tb_analog_block_test_mux_control.sv ====
// Self-checking bench for the analog block test mux control registers.
module tb_analog_block_test_mux_control;
  timeunit 1ns;
  timeprecision 100ps;
  import abtm_pkg::*;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic clk_i, rst_i, cyc_i, stb_i, we_i, gpio_out_i, gpio_oe_i, ack_o;
  logic [ADR_W-1:0] adr_i;
  logic [SEL_W-1:0] sel_i;
  logic [DAT_W-1:0] dat_i, dat_o, q;
  logic [ASEL_W-1:0] converter_channel_select_i, analog_mux_select_o;
  logic [DSRC_N-1:0] digital_test_source_i;
  logic current_loop_amp_off_ch1_o, voltage_loop_amp_off_ch1_o;
  logic current_loop_amp_off_ch2_o, voltage_loop_amp_off_ch2_o;
  logic aux_amp_gain_select_o, gate_drive_lockout_select_o;
  logic analog_buffer_enable_o, analog_test_pin_connect_o;
  logic analog_test_pin_input_keep_o, digital_test_pin_o;
  logic digital_test_pin_oe_o;
  logic [REG_W-1:0] r1, r2;
  int fails, total_checks;
  // Rows: address, write byte, expected read-back byte.
  logic [27:0] rows [7] = '{28'h430FFFF, 28'h434FF76, 28'h4300000,
    28'h4348900, 28'h4304A4A, 28'h4342424, 28'h438FF00};
  localparam logic [31:0] SRC = 32'hA5C31E96;

  abtm_top DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .ack_o, .dat_o, .current_loop_amp_off_ch1_o,
    .voltage_loop_amp_off_ch1_o, .current_loop_amp_off_ch2_o,
    .voltage_loop_amp_off_ch2_o, .aux_amp_gain_select_o,
    .gate_drive_lockout_select_o, .converter_channel_select_i,
    .analog_mux_select_o, .analog_buffer_enable_o,
    .analog_test_pin_connect_o, .analog_test_pin_input_keep_o,
    .digital_test_source_i, .gpio_out_i, .gpio_oe_i,
    .digital_test_pin_o, .digital_test_pin_oe_o);

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task report_and_stop;
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // The request is held until ack is seen; the wait has no own bound.
  task wb(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic [3:0] s);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, 24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb

  task outs_chk;
    chk(32'({current_loop_amp_off_ch1_o, voltage_loop_amp_off_ch1_o,
      aux_amp_gain_select_o, gate_drive_lockout_select_o,
      current_loop_amp_off_ch2_o, voltage_loop_amp_off_ch2_o}),
      32'({r1[2], r1[1], r1[6], r1[3], r2[2], r2[1]}));
  endtask : outs_chk

  task regs_zero;
    r1 = 8'h00;
    r2 = 8'h00;
    outs_chk;
    chk(32'({analog_test_pin_connect_o, analog_test_pin_input_keep_o,
      digital_test_pin_oe_o}), 32'h2);
    wb(1'b0, 12'h430, 8'h00, 4'hF);
    chk(q, 32'h0);
    wb(1'b0, 12'h434, 8'h00, 4'hF);
    chk(q, 32'h0);
  endtask : regs_zero

  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    rst_i = 1'b1;
    {gpio_out_i, gpio_oe_i} = 2'b00;
    converter_channel_select_i = 5'h13;
    digital_test_source_i = SRC;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(analog_test_pin_input_keep_o), 32'h1);
    regs_zero;
    foreach (rows[i]) begin
      wb(1'b1, rows[i][27:16], rows[i][15:8], 4'hF);
      if (rows[i][27:16] == 12'h430) r1 = rows[i][7:0];
      if (rows[i][27:16] == 12'h434) r2 = rows[i][7:0];
      outs_chk;
      wb(1'b0, rows[i][27:16], 8'h00, 4'hF);
      chk(q, 32'(rows[i][7:0]));
    end
    // A write with its byte lane off must leave the register alone.
    wb(1'b1, 12'h430, 8'hFF, 4'h0);
    wb(1'b0, 12'h430, 8'h00, 4'hF);
    chk(q, 32'(r1));
    for (int s = 0; s < 32; s++) begin
      wb(1'b1, 12'h430, {2'b10, s[1:0], 4'h0}, 4'h1);
      wb(1'b1, 12'h434, {1'b0, s[4:2], 4'h0}, 4'h1);
      repeat (2) @(posedge clk_i);
      chk(32'({digital_test_pin_o, digital_test_pin_oe_o}),
        32'({SRC[s], 1'b1}));
    end
    {gpio_out_i, gpio_oe_i} <= 2'b11;
    wb(1'b1, 12'h430, 8'h30, 4'h1);
    repeat (2) @(posedge clk_i);
    chk(32'({digital_test_pin_o, digital_test_pin_oe_o}), 32'h3);
    // Both pin drive inputs low: a leaking test select would show here.
    {gpio_out_i, gpio_oe_i} <= 2'b00;
    repeat (2) @(posedge clk_i);
    chk(32'({digital_test_pin_o, digital_test_pin_oe_o}), 32'h0);
    wb(1'b1, 12'h430, 8'h01, 4'h1);
    converter_channel_select_i <= 5'h0C;
    repeat (2) @(posedge clk_i);
    chk(32'({analog_mux_select_o, analog_buffer_enable_o,
      analog_test_pin_connect_o, analog_test_pin_input_keep_o}),
      32'({5'h0C, 3'b110}));
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    regs_zero;
    report_and_stop;
  end

  initial begin
    #20000;
    fails++;
    report_and_stop;
  end
endmodule : tb_analog_block_test_mux_control
